/* File: hdl/flash_access_security_control.sv */
// Purpose: flash access control, debug locks, access limit, control SFRs
// Assumes: one-cycle flash array; requests held until ack
// Notes: lock bytes are mirrored from the array at their fixed addresses
// Summary of operation
// - Read lock bit 0 blocks debug reads
// - Write/erase lock bit 0 blocks debug changes
// - Locked security block: writes yes, erase no
// - Upper code cannot touch flash below limit
// - Upper table read below limit returns zero
// - Lower code unrestricted; upper may execute lower
// - Limit address is register byte then 0x00
// - Limit register takes first write only
// - Limit reads zero until written
// - Debug port obeys locks for read/write/erase
// - Debug may always read locks, lock more
// - Unlocked security page erase clears all locks
// - Locked security page needs full device erase
// - Reserved area never accessible, except CPU fetches while scratchpad select is set
// - Locks ignore software; software never erases sec page
// - One-shot bit powers sense amps down; reset 1
// - Read-always bit reads every cycle
// - Software write/erase needs global enable
// - Scratchpad select steers software reads/writes
// - Erase plus write enable erases whole page
// - Write enable sends data-move writes to flash
// - Each lock bit governs one 8 kB block
// - Byte write clears bits; erase sets 0xFF
`include "fasc_defs.svh"
`default_nettype none
module fasc_flash_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sfrWe,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic cpuFetch,
  input wire logic [15:0] cpuPc,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0] cpuWdata,
  output logic cpuAck,
  output logic cpuDenied,
  output logic cpuToXram,
  output logic [7:0] cpuRdata,
  input wire logic dbgReq,
  input wire logic [1:0] dbgOp,
  input wire logic [15:0] dbgAddr,
  input wire logic [7:0] dbgWdata,
  output logic dbgAck,
  output logic dbgDenied,
  output logic [7:0] dbgRdata,
  output logic flashRead,
  output logic flashWrite,
  output logic flashPageErase,
  output logic flashMassErase,
  output logic flashScratch,
  output logic [15:0] flashAddr,
  output logic [7:0] flashWdata,
  input wire logic [7:0] flashRdata,
  output logic senseAmpOff,
  output logic [15:0] accessLimitAddress
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic lockBit(input logic [7:0] lb,
                                   input logic [15:0] a);
    lockBit = lb[a[`FASC_BLOCK_MSB:`FASC_BLOCK_LSB]];
  endfunction
  function automatic logic secPage(input logic [15:0] a);
    secPage = a[`FASC_PAGE_MSB:`FASC_PAGE_LSB] == `FASC_SEC_PAGE;
  endfunction
  function automatic logic isLockAddr(input logic [15:0] a);
    isLockAddr = a == `FASC_LOCK_WE_ADDR || a == `FASC_LOCK_RD_ADDR;
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] storeCtlQ;
  logic [7:0] memCtlQ;
  logic [7:0] limitQ;
  logic limitDoneQ;
  logic [7:0] rdLockQ;
  logic [7:0] weLockQ;
  fasc_pkg::fasc_state_t stateQ;
  fasc_pkg::fasc_src_t srcQ;
  logic [3:0] oneShotQ;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      storeCtlQ <= `FASC_STORE_CTL_RESET;
      memCtlQ <= `FASC_MEM_CTL_RESET;
    end else if (sfrWe) begin
      if (sfrAddr == `FASC_SFR_STORE_CTL_ADDR) begin
        storeCtlQ <= sfrWdata & `FASC_STORE_CTL_MASK;
      end else if (sfrAddr == `FASC_SFR_MEM_CTL_ADDR) begin
        memCtlQ <= sfrWdata & `FASC_MEM_CTL_MASK;
      end
    end
  end

  // Only the first write after reset lands; no software path reopens it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limitQ <= `FASC_LIMIT_RESET;
      limitDoneQ <= 1'b0;
    end else if (sfrWe && sfrAddr == `FASC_SFR_LIMIT_ADDR &&
                 !limitDoneQ) begin
      limitQ <= sfrWdata;
      limitDoneQ <= 1'b1;
    end
  end

  // Registered read keeps every port on a flop; data lags one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdata <= `FASC_ZERO_BYTE;
    end else if (sfrAddr == `FASC_SFR_STORE_CTL_ADDR) begin
      sfrRdata <= storeCtlQ;
    end else if (sfrAddr == `FASC_SFR_MEM_CTL_ADDR) begin
      sfrRdata <= memCtlQ;
    end else if (sfrAddr == `FASC_SFR_LIMIT_ADDR) begin
      sfrRdata <= limitQ;
    end else begin
      sfrRdata <= `FASC_ZERO_BYTE;
    end
  end

  logic [15:0] limitAddr;
  assign limitAddr = {limitQ, `FASC_ZERO_BYTE};

  // ----------------------------------------------------------------
  // Permission decode
  // ----------------------------------------------------------------
  logic wrEn;
  logic erEn;
  logic scratch;
  assign wrEn = storeCtlQ[`FASC_BIT_WREN];
  assign erEn = storeCtlQ[`FASC_BIT_ERASE];
  assign scratch = storeCtlQ[`FASC_BIT_SCRATCH];

  logic cpuUpper;
  logic cpuBelow;
  logic cpuRsv;
  logic cpuFlashWr;
  logic cpuErase;
  logic cpuOk;
  always_comb begin
    cpuUpper = cpuPc >= limitAddr;
    cpuBelow = cpuAddr < limitAddr;
    cpuRsv = !scratch && cpuAddr >= `FASC_RSV_BASE;
    cpuFlashWr = cpuWrite && wrEn;
    cpuErase = cpuFlashWr && erEn;
    cpuOk = 1'b1;
    // A write never takes the fetch path, so it cannot skip the checks
    if (cpuFetch && !cpuWrite) begin
      cpuOk = !cpuRsv;
    end else if (cpuRsv) begin
      cpuOk = 1'b0;
    end else if (cpuUpper && cpuBelow && !scratch) begin
      cpuOk = 1'b0;
    end else if (cpuFlashWr && !memCtlQ[`FASC_BIT_WREN]) begin
      cpuOk = 1'b0;
    end else if (cpuErase && !scratch && secPage(cpuAddr)) begin
      cpuOk = 1'b0;
    end
  end

  logic dbgRsv;
  logic dbgSecLocked;
  logic dbgOk;
  logic dbgMass;
  always_comb begin
    dbgRsv = dbgAddr >= `FASC_RSV_BASE;
    dbgSecLocked = !lockBit(weLockQ, `FASC_LOCK_WE_ADDR);
    dbgMass = 1'b0;
    dbgOk = 1'b0;
    if (dbgRsv) begin
      dbgOk = 1'b0;
    end else if (dbgOp == 2'b00) begin
      dbgOk = isLockAddr(dbgAddr) || lockBit(rdLockQ, dbgAddr);
    end else if (dbgOp == 2'b01) begin
      // Writes only clear bits, so a lock byte write only locks more
      dbgOk = isLockAddr(dbgAddr) || lockBit(weLockQ, dbgAddr);
    end else if (isLockAddr(dbgAddr) && dbgSecLocked) begin
      dbgOk = 1'b1;
      dbgMass = 1'b1;
    end else begin
      dbgOk = lockBit(weLockQ, dbgAddr);
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // CPU wins a tie; the debug request simply waits a turn
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= fasc_pkg::FASC_IDLE;
      srcQ <= fasc_pkg::FASC_SRC_NONE;
      cpuAck <= 1'b0;
      cpuDenied <= 1'b0;
      cpuToXram <= 1'b0;
      cpuRdata <= `FASC_ZERO_BYTE;
      dbgAck <= 1'b0;
      dbgDenied <= 1'b0;
      dbgRdata <= `FASC_ZERO_BYTE;
      flashRead <= 1'b0;
      flashWrite <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
      flashScratch <= 1'b0;
      flashAddr <= 16'h0000;
      flashWdata <= `FASC_ZERO_BYTE;
    end else begin
      cpuAck <= 1'b0;
      dbgAck <= 1'b0;
      flashWrite <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
      flashRead <= memCtlQ[`FASC_BIT_READ_ALWAYS];
      case (stateQ)
        fasc_pkg::FASC_IDLE: begin
          if (cpuReq && !cpuAck) begin
            cpuDenied <= 1'b0;
            cpuToXram <= 1'b0;
            if (cpuWrite && !wrEn) begin
              cpuAck <= 1'b1;
              cpuToXram <= 1'b1;
            end else if (!cpuOk) begin
              cpuAck <= 1'b1;
              cpuDenied <= 1'b1;
              cpuRdata <= `FASC_ZERO_BYTE;
            end else begin
              srcQ <= fasc_pkg::FASC_SRC_CPU;
              flashScratch <= scratch && !cpuFetch;
              flashAddr <= (scratch && !cpuFetch) ?
                           (cpuAddr & `FASC_SCRATCH_MASK) : cpuAddr;
              flashWdata <= cpuWdata;
              if (cpuErase) begin
                flashPageErase <= 1'b1;
                stateQ <= fasc_pkg::FASC_ERASE;
              end else if (cpuWrite) begin
                flashWrite <= 1'b1;
                stateQ <= fasc_pkg::FASC_WRITE;
              end else begin
                flashRead <= 1'b1;
                stateQ <= fasc_pkg::FASC_READ;
              end
            end
          end else if (dbgReq && !dbgAck) begin
            dbgDenied <= 1'b0;
            if (!dbgOk) begin
              dbgAck <= 1'b1;
              dbgDenied <= 1'b1;
              dbgRdata <= `FASC_ZERO_BYTE;
            end else begin
              srcQ <= fasc_pkg::FASC_SRC_DBG;
              flashScratch <= 1'b0;
              flashAddr <= dbgAddr;
              flashWdata <= dbgWdata;
              if (dbgOp == 2'b00) begin
                flashRead <= 1'b1;
                stateQ <= fasc_pkg::FASC_READ;
              end else if (dbgOp == 2'b01) begin
                flashWrite <= 1'b1;
                stateQ <= fasc_pkg::FASC_WRITE;
              end else begin
                flashPageErase <= !dbgMass;
                flashMassErase <= dbgMass;
                stateQ <= fasc_pkg::FASC_ERASE;
              end
            end
          end
        end
        fasc_pkg::FASC_READ: begin
          if (srcQ == fasc_pkg::FASC_SRC_CPU) begin
            cpuAck <= 1'b1;
            cpuRdata <= flashRdata;
          end else begin
            dbgAck <= 1'b1;
            dbgRdata <= flashRdata;
          end
          stateQ <= fasc_pkg::FASC_IDLE;
        end
        fasc_pkg::FASC_WRITE,
        fasc_pkg::FASC_ERASE: begin
          if (srcQ == fasc_pkg::FASC_SRC_CPU) begin
            cpuAck <= 1'b1;
          end else begin
            dbgAck <= 1'b1;
          end
          stateQ <= fasc_pkg::FASC_IDLE;
        end
        default: begin
          stateQ <= fasc_pkg::FASC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Lock byte mirror
  // ----------------------------------------------------------------
  // Erased flash reads 0xFF, so after reset every block starts open
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdLockQ <= `FASC_ERASED_BYTE;
      weLockQ <= `FASC_ERASED_BYTE;
    end else if (flashMassErase ||
                 (flashPageErase && !flashScratch &&
                  secPage(flashAddr))) begin
      rdLockQ <= `FASC_ERASED_BYTE;
      weLockQ <= `FASC_ERASED_BYTE;
    end else if (flashWrite && !flashScratch) begin
      if (flashAddr == `FASC_LOCK_RD_ADDR) begin
        rdLockQ <= rdLockQ & flashWdata;
      end else if (flashAddr == `FASC_LOCK_WE_ADDR) begin
        weLockQ <= weLockQ & flashWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sense amp one-shot and limit output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oneShotQ <= 4'h0;
      senseAmpOff <= 1'b0;
      accessLimitAddress <= 16'h0000;
    end else begin
      accessLimitAddress <= limitAddr;
      if (flashRead) begin
        oneShotQ <= `FASC_ONE_SHOT_CYC;
        senseAmpOff <= 1'b0;
      end else if (oneShotQ != 4'h0) begin
        oneShotQ <= oneShotQ - 4'h1;
      end else begin
        senseAmpOff <= memCtlQ[`FASC_BIT_ONE_SHOT];
      end
    end
  end
endmodule
`default_nettype wire

/* File: common/fasc_defs.svh */
// Purpose: constants for the flash access and security control block
// Assumes: 64 kB program space, 512-byte pages, 8 kB lock blocks
// Notes: definitions only
`ifndef FASC_DEFS_SVH
`define FASC_DEFS_SVH
`define FASC_SFR_STORE_CTL_ADDR 8'h8f
`define FASC_SFR_MEM_CTL_ADDR 8'hb7
`define FASC_SFR_LIMIT_ADDR 8'hb6
`define FASC_STORE_CTL_RESET 8'h00
`define FASC_MEM_CTL_RESET 8'h80
`define FASC_LIMIT_RESET 8'h00
`define FASC_STORE_CTL_MASK 8'h07
`define FASC_MEM_CTL_MASK 8'hc1
`define FASC_BIT_WREN 0
`define FASC_BIT_ERASE 1
`define FASC_BIT_SCRATCH 2
`define FASC_BIT_READ_ALWAYS 6
`define FASC_BIT_ONE_SHOT 7
`define FASC_LOCK_WE_ADDR 16'hfbfe
`define FASC_LOCK_RD_ADDR 16'hfbff
`define FASC_SEC_PAGE 7'h7d
`define FASC_RSV_BASE 16'hfc00
`define FASC_SCRATCH_MASK 16'h007f
`define FASC_ERASED_BYTE 8'hff
`define FASC_ZERO_BYTE 8'h00
`define FASC_PAGE_MSB 15
`define FASC_PAGE_LSB 9
`define FASC_BLOCK_MSB 15
`define FASC_BLOCK_LSB 13
`define FASC_ONE_SHOT_CYC 4'h3
`endif

/* File: common/fasc_pkg.sv */
// Purpose: shared types of the flash access and security control block
// Assumes: nothing beyond the defines header
// Notes: states Gray coded along the usual path
`default_nettype none
package fasc_pkg;
  typedef enum logic [1:0] {
    FASC_IDLE = 2'b00,
    FASC_READ = 2'b01,
    FASC_WRITE = 2'b11,
    FASC_ERASE = 2'b10
  } fasc_state_t;
  typedef enum logic [1:0] {
    FASC_SRC_NONE = 2'b00,
    FASC_SRC_CPU = 2'b01,
    FASC_SRC_DBG = 2'b10
  } fasc_src_t;
endpackage
`default_nettype wire

/* File: testbench/fasc_checker.sv */
// Purpose: port-level checks of the flash access controller
// Assumes: one idle cycle between requests on each port
// Notes: control bits mirrored from register writes seen at the ports
`default_nettype none
module fasc_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sfrWe,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic cpuAck,
  input wire logic cpuDenied,
  input wire logic cpuToXram,
  input wire logic [7:0] cpuRdata,
  input wire logic dbgReq,
  input wire logic [15:0] dbgAddr,
  input wire logic dbgAck,
  input wire logic dbgDenied,
  input wire logic flashRead,
  input wire logic flashWrite,
  input wire logic flashPageErase,
  input wire logic [15:0] flashAddr,
  input wire logic senseAmpOff,
  input wire logic [15:0] accessLimitAddress
);
  // --------------------------------------------------------------
  // Register mirrors and properties
  // --------------------------------------------------------------
  logic wren_q, storeWe_q, oneShot_q, readAll_q, limSet_q;
  logic [7:0] limVal_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {oneShot_q, readAll_q, wren_q, storeWe_q, limSet_q} <= 5'h10;
      limVal_q <= 8'h00;
    end else if (sfrWe) begin
      if (sfrAddr == 8'h8f) storeWe_q <= sfrWdata[0];
      if (sfrAddr == 8'hb7) {oneShot_q, readAll_q} <= sfrWdata[7:6];
      if (sfrAddr == 8'hb7) wren_q <= sfrWdata[0];
      // Only the first write counts, as in the block itself
      if (sfrAddr == 8'hb6 && !limSet_q) limVal_q <= sfrWdata;
      if (sfrAddr == 8'hb6) limSet_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence cpuWr;
    $rose(cpuReq) ##0 cpuWrite;
  endsequence
  a_limit_value: assert property (limSet_q && $past(limSet_q) |->
    accessLimitAddress == {limVal_q, 8'h00}) else $error("limit wrong");
  a_limit_reset: assert property (!limSet_q |->
    accessLimitAddress == 16'h0000) else $error("limit not zero");
  a_xram_write: assert property (cpuWr ##0 !storeWe_q |-> ##1
    (cpuAck && cpuToXram && !flashWrite)) else $error("xram write lost");
  a_write_needs_en: assert property (cpuWr ##0 storeWe_q && !wren_q
    |-> ##1 (cpuAck && cpuDenied && !flashWrite && !flashPageErase))
    else $error("write without enable");
  a_denied_zero: assert property (cpuAck && cpuDenied |->
    cpuRdata == 8'h00) else $error("denied read not zero");
  a_reserved_dbg: assert property ($rose(dbgReq) && dbgAddr >= 16'hfc00
    |-> ##1 (dbgAck && dbgDenied)) else $error("reserved debug access");
  a_reserved_flash: assert property (flashWrite || flashPageErase |->
    flashAddr < 16'hfc00) else $error("reserved area changed");
  a_read_always: assert property (readAll_q && $past(readAll_q) |->
    flashRead) else $error("read always idle");
  a_sense_on: assert property (!oneShot_q && $past(!oneShot_q) |->
    !senseAmpOff) else $error("sense amps off without one-shot");
endmodule
`default_nettype wire

/* File: testbench/fasc_flash_model.sv */
// Purpose: behavioural flash array facing the controller
// Assumes: one-cycle array, 512-byte pages, erased bytes read 0xFF
// Notes: read data inverts between reads so stale data never matches
`default_nettype none
module fasc_flash_model (
  input wire logic clk_sys,
  input wire logic flashRead,
  input wire logic flashWrite,
  input wire logic flashPageErase,
  input wire logic flashMassErase,
  input wire logic flashScratch,
  input wire logic [15:0] flashAddr,
  input wire logic [7:0] flashWdata,
  output logic [7:0] flashRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Array
  // --------------------------------------------------------------
  logic [7:0] mem [bit [16:0]];
  logic [16:0] a;
  logic [15:0] scratchMask;
  assign scratchMask = flashScratch ? 16'h007f : 16'hffff;
  assign a = {flashScratch, flashAddr & scratchMask};
  // Changes land on the rising edge that samples their strobe
  always @(posedge clk_sys) begin
    if (flashMassErase) begin
      mem.delete();
    end
    if (flashPageErase) begin
      for (int i = 0; i < 512; i++) begin
        mem.delete({a[16:9], 9'(i)});
      end
    end
    if (flashWrite) begin
      mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & flashWdata;
    end
  end
  // Read data settles mid-strobe; the controller takes it at strobe end
  always @(negedge clk_sys) begin
    if (flashRead) begin
      flashRdata <= mem.exists(a) ? mem[a] : 8'hff;
    end else begin
      flashRdata <= ~flashRdata;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/fasc_flash_ctrl_tb.sv */
// Purpose: self-checking bench of the flash access controller
// Assumes: flash model answers within the read strobe cycle
// Notes: expected answers queued by the driver, popped on each ack
`default_nettype none
module fasc_flash_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, sfrWe = 0, cpuReq = 0, cpuWrite = 0;
  logic cpuFetch = 0, dbgReq = 0, den;
  logic [7:0] sfrAddr = '0, sfrWdata = '0, cpuWdata = '0, dbgWdata = '0;
  logic [15:0] cpuPc = '0, cpuAddr = '0, dbgAddr = '0;
  logic [1:0] dbgOp = '0;
  logic [7:0] sfrRdata, cpuRdata, dbgRdata, flashRdata, flashWdata, rd;
  logic [15:0] flashAddr, accessLimitAddress;
  logic cpuAck, cpuDenied, cpuToXram, dbgAck, dbgDenied, flashRead;
  logic flashWrite, flashPageErase, flashMassErase, flashScratch;
  logic senseAmpOff;
  logic [9:0] expQ [$];
  logic [9:0] e;
  logic [15:0] rv [4] = '{16'h8f00, 16'hb780, 16'hb600, 16'h1000};
  logic [31:0] seed = 32'h2b44_d47a;
  int mismatches = 0, n_compared = 0;
  // --------------------------------------------------------------
  // Harness, tasks and scenarios
  // --------------------------------------------------------------
  fasc_flash_ctrl DUT (.clk_sys, .rst_n, .sfrWe, .sfrAddr, .sfrWdata,
    .sfrRdata, .cpuReq, .cpuWrite, .cpuFetch, .cpuPc, .cpuAddr, .cpuWdata,
    .cpuAck, .cpuDenied, .cpuToXram, .cpuRdata, .dbgReq, .dbgOp, .dbgAddr,
    .dbgWdata, .dbgAck, .dbgDenied, .dbgRdata, .flashRead, .flashWrite,
    .flashPageErase, .flashMassErase, .flashScratch, .flashAddr,
    .flashWdata, .flashRdata, .senseAmpOff, .accessLimitAddress);
  fasc_flash_model FLASH (.clk_sys, .flashRead, .flashWrite,
    .flashPageErase, .flashMassErase, .flashScratch, .flashAddr,
    .flashWdata, .flashRdata);
  initial forever #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic sfrw(input logic [7:0] a, d);
    @(negedge clk_sys);
    {sfrWe, sfrAddr, sfrWdata} = {1'b1, a, d};
    @(negedge clk_sys);
    sfrWe = 0;
  endtask
  // Debug k is the op code; CPU k is {fetch, write}; ex is {chk, den, data}
  task automatic req(input bit dbg, input logic [1:0] k,
      input logic [15:0] pc, a, input logic [7:0] d, input logic [9:0] ex);
    expQ.push_back(ex);
    @(negedge clk_sys);
    if (dbg) {dbgReq, dbgOp, dbgAddr, dbgWdata} = {1'b1, k, a, d};
    else {cpuReq, cpuWrite, cpuFetch, cpuPc, cpuAddr, cpuWdata} =
      {1'b1, k[0], k[1], pc, a, d};
    repeat (6) begin
      @(posedge clk_sys);
      if ((dbg ? dbgAck : cpuAck) === 1'b1) break;
    end
    @(negedge clk_sys);
    {cpuReq, dbgReq} = 2'b00;
  endtask
  always @(posedge clk_sys) begin
    if (cpuAck === 1'b1 || dbgAck === 1'b1) begin
      // An ack with nothing queued is bound to mismatch
      e = expQ.size() > 0 ? expQ.pop_front() : 10'h3ff;
      den = cpuAck === 1'b1 ? cpuDenied : dbgDenied;
      rd = cpuAck === 1'b1 ? cpuRdata : dbgRdata;
      check("denied", den, e[8]);
      if (e[9]) check("read data", rd, e[7:0]);
    end
  end
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1;
    foreach (rv[i]) begin
      sfrAddr = rv[i][15:8];
      @(negedge clk_sys);
      check("reset value", sfrRdata, rv[i][7:0]);
    end
    req(0, 1, 0, 16'h1000, 8'h5a, 10'h000);
    sfrw(8'h8f, 8'h01);
    req(0, 1, 0, 16'h1000, 8'h5a, 10'h300);
    sfrw(8'hb7, 8'h81);
    req(0, 1, 0, 16'h1000, 8'h5a, 10'h000);
    req(0, 1, 0, 16'h1000, 8'h0f, 10'h000);
    req(0, 0, 0, 16'h1000, 8'h00, 10'h20a);
    sfrw(8'h8f, 8'h03);
    req(0, 1, 0, 16'h1000, 8'h00, 10'h000);
    req(0, 1, 0, 16'hfa10, 8'h00, 10'h300);
    sfrw(8'h8f, 8'h01);
    req(0, 0, 0, 16'h1000, 8'h00, 10'h2ff);
    req(0, 1, 0, 16'hfa10, 8'h3c, 10'h000);
    req(0, 0, 0, 16'hfc00, 8'h00, 10'h300);
    req(0, 1, 0, 16'hfc10, 8'h00, 10'h300);
    req(1, 0, 0, 16'hfd00, 8'h00, 10'h100);
    sfrw(8'h8f, 8'h05);
    req(0, 1, 0, 16'h0010, 8'h33, 10'h000);
    req(0, 0, 0, 16'h0010, 8'h00, 10'h233);
    sfrw(8'h8f, 8'h01);
    req(0, 0, 0, 16'h0010, 8'h00, 10'h2ff);
    sfrw(8'hb6, 8'h20);
    sfrw(8'hb6, 8'h40);
    check("limit", accessLimitAddress, 16'h2000);
    req(0, 0, 16'h3000, 16'h1000, 8'h00, 10'h300);
    req(0, 1, 16'h3000, 16'h1000, 8'h00, 10'h300);
    req(0, 2, 16'h3000, 16'h1000, 8'h00, 10'h2ff);
    req(0, 0, 16'h1000, 16'h3000, 8'h00, 10'h2ff);
    req(0, 0, 16'h3000, 16'h2000, 8'h00, 10'h2ff);
    repeat (4) begin
      seed = xs(seed);
      req(0, 0, 0, {3'h2, seed[12:0]}, 8'h00, 10'h2ff);
    end
    req(1, 1, 0, 16'hfbff, 8'hfe, 10'h000);
    req(1, 0, 0, 16'h1000, 8'h00, 10'h100);
    req(1, 0, 0, 16'h2000, 8'h00, 10'h2ff);
    req(1, 0, 0, 16'hfbff, 8'h00, 10'h2fe);
    req(1, 1, 0, 16'hfbfe, 8'hfe, 10'h000);
    req(1, 1, 0, 16'h0010, 8'h00, 10'h100);
    req(1, 2, 0, 16'h0010, 8'h00, 10'h100);
    req(1, 1, 0, 16'h2010, 8'h55, 10'h000);
    req(1, 2, 0, 16'hfa00, 8'h00, 10'h000);
    req(1, 0, 0, 16'h1000, 8'h00, 10'h2ff);
    req(1, 1, 0, 16'hfbfe, 8'h7f, 10'h000);
    req(1, 1, 0, 16'hfbfe, 8'h7e, 10'h000);
    req(1, 2, 0, 16'hfa00, 8'h00, 10'h100);
    req(1, 3, 0, 16'hfbfe, 8'h00, 10'h000);
    req(1, 0, 0, 16'h2010, 8'h00, 10'h2ff);
    repeat (6) @(negedge clk_sys);
    check("sense off", senseAmpOff, 1'b1);
    // Mid-run reset must reopen the limit register for one write
    @(negedge clk_sys);
    rst_n = 0;
    @(negedge clk_sys);
    rst_n = 1;
    sfrAddr = 8'hb7;
    @(negedge clk_sys);
    check("reset value", sfrRdata, 8'h80);
    check("limit reset", accessLimitAddress, 16'h0000);
    sfrw(8'hb6, 8'h60);
    sfrw(8'hb6, 8'h20);
    check("limit rewrite", accessLimitAddress, 16'h6000);
    sfrw(8'hb7, 8'h40);
    repeat (6) @(negedge clk_sys);
    check("queue", expQ.size(), 0);
    final_report();
  end
endmodule
bind fasc_flash_ctrl fasc_checker CHK (.clk_sys, .rst_n, .sfrWe, .sfrAddr,
  .sfrWdata, .cpuReq, .cpuWrite, .cpuAck, .cpuDenied, .cpuToXram, .cpuRdata,
  .dbgReq, .dbgAddr, .dbgAck, .dbgDenied, .flashRead, .flashWrite,
  .flashPageErase, .flashAddr, .senseAmpOff, .accessLimitAddress);
`default_nettype wire
